// *** hw/feature_cmds.sv ***
// Feature-configuration and temperature-sense command decoder
`timescale 1ns/1ps
`include "feat_defs.svh"

module feature_cmds (
    // Clock and resets
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        soft_reset_i,
    // Task-file command
    input  wire logic        cmd_valid_i,
    input  wire logic [7:0]  cmd_opcode_i,
    input  wire logic [7:0]  cmd_feature_i,
    input  wire logic [7:0]  cmd_count_i,
    input  wire logic [7:0]  cmd_lba_low_i,
    input  wire logic [7:0]  cmd_lba_mid_i,
    input  wire logic [7:0]  cmd_lba_high_i,
    // Device conditions
    input  wire logic signed [7:0] temp_c_i,
    input  wire logic        spares_exhausted_i,
    // Task-file results
    output logic [7:0]       result_count_o,
    output logic [7:0]       error_flags_o,
    output logic [7:0]       status_flags_o,
    output logic             done_o,
    // Feature state
    output logic             write_cache_o,
    output logic             read_ahead_o,
    output logic             revert_defaults_o,
    output logic             release_irq_o,
    output logic             puis_enable_o,
    output logic             puis_spinup_o,
    output logic             pio_ready_handshake_o,
    output logic [4:0]       xfer_type_o,
    output logic [2:0]       xfer_mode_o,
    output logic [`LINK_SUBFEATS-1:0] link_feat_o,
    output logic             pm_enable_o,
    output logic [7:0]       power_management_level_o,
    output feat_pkg::pm_depth_t pm_depth_o,
    output logic [15:0]      lpi_time_s_o,
    output logic [15:0]      stby_time_s_o,
    output logic             lpi_time_set_o,
    output logic [15:0]      pio_sector_time_o,
    output logic [15:0]      dma_sector_time_o,
    output logic             full_rate_pio_o,
    output logic             full_rate_dma_o
);

    // ==========================================================
    // Decode helpers
    function automatic logic xfer_ok(input logic [7:0] c);
        logic [4:0] t;
        logic [2:0] m;
        t = c[7:3];
        m = c[2:0];
        case (t)
            `XT_PIO_DEFAULT: xfer_ok = (m <= 3'h1);
            `XT_PIO_FLOW:    xfer_ok = (m <= `XM_PIO_MAX);
            `XT_MW_DMA:      xfer_ok = (m <= `XM_MW_MAX);
            `XT_ULTRA_DMA:   xfer_ok = (m <= `XM_UDMA_MAX);
            default:         xfer_ok = 1'b0;
        endcase
    endfunction

    function automatic logic link_ok(input logic [7:0] c);
        link_ok = (c == 8'h01) || (c == 8'h02) || (c == 8'h03) ||
                  (c == 8'h04) || (c == 8'h06);
    endfunction

    function automatic logic sub_known(input logic [7:0] f);
        case (f)
            `SF_WCACHE_ON, `SF_XFER_MODE, `SF_PM_ON, `SF_PUIS_ON,
            `SF_PUIS_SPINUP, `SF_LINK_ON, `SF_SECTOR_TIME,
            `SF_RLA_OFF, `SF_REVERT_OFF, `SF_WCACHE_OFF, `SF_PM_OFF,
            `SF_PUIS_OFF, `SF_LINK_OFF, `SF_RLA_ON,
            `SF_REVERT_ON: sub_known = 1'b1;
            default:       sub_known = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Command acceptance
    logic       is_temp;
    logic       is_feat;
    logic       abort_d;
    logic       feat_go;
    logic [7:0] cnt;
    logic [7:0] sub;
    logic       soft_revert;
    logic [7:0] temp_code;

    assign cnt = cmd_count_i;
    assign sub = cmd_feature_i;
    assign is_temp = cmd_valid_i && (cmd_opcode_i == `OP_TEMP_SENSE);
    assign is_feat = cmd_valid_i && (cmd_opcode_i == `OP_SET_FEATURE);
    assign soft_revert = soft_reset_i && revert_defaults_o;

    always_comb begin
        abort_d = 1'b0;
        if (is_temp) begin
            abort_d = (sub != `TEMP_FEATURE);
        end else if (is_feat) begin
            if (!sub_known(sub)) begin
                abort_d = 1'b1;
            end else if (sub == `SF_XFER_MODE) begin
                abort_d = !xfer_ok(cnt);
            end else if (sub == `SF_LINK_ON || sub == `SF_LINK_OFF) begin
                abort_d = !link_ok(cnt);
            end else if (sub == `SF_PM_ON) begin
                abort_d = (cnt == 8'hff) || (cnt == 8'h00);
            end
        end
    end
    assign feat_go = is_feat && !abort_d && !status_flags_o[`ST_BUSY_BIT];

    temp_encode u_temp (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .temp_c_i (temp_c_i),
        .code_o   (temp_code)
    );

    // ==========================================================
    // Completion and task-file results
    logic pend_q;
    logic pend_abort_q;
    logic pend_temp_q;

    // Temperature sense ignores standby state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q       <= 1'b0;
            pend_abort_q <= 1'b0;
            pend_temp_q  <= 1'b0;
        end else begin
            pend_q       <= (is_temp || is_feat) && !status_flags_o[`ST_BUSY_BIT];
            pend_abort_q <= abort_d;
            pend_temp_q  <= is_temp;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_flags_o  <= 8'h00;
            status_flags_o <= 8'h40;
            result_count_o <= 8'h00;
            done_o         <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if ((is_temp || is_feat) && !status_flags_o[`ST_BUSY_BIT]) begin
                status_flags_o[`ST_BUSY_BIT] <= 1'b1;
            end else if (pend_q) begin
                done_o <= 1'b1;
                status_flags_o[`ST_BUSY_BIT]  <= 1'b0;
                status_flags_o[`ST_ERROR_BIT] <= pend_abort_q;
                error_flags_o[`ERR_ABORT_BIT] <= pend_abort_q;
                if (pend_temp_q && !pend_abort_q) begin
                    result_count_o <= temp_code;
                end
            end
        end
    end

    // ==========================================================
    // Cache, look-ahead, revert, standby
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_cache_o     <= 1'b1;
            read_ahead_o      <= 1'b1;
            revert_defaults_o <= 1'b0;
            release_irq_o     <= 1'b0;
        end else begin
            if (spares_exhausted_i) begin
                write_cache_o <= 1'b0;
            end else if (soft_revert) begin
                write_cache_o <= 1'b1;
                read_ahead_o  <= 1'b1;
            end else if (feat_go) begin
                case (sub)
                    `SF_WCACHE_ON:  write_cache_o <= 1'b1;
                    `SF_WCACHE_OFF: write_cache_o <= 1'b0;
                    `SF_RLA_ON:     read_ahead_o  <= 1'b1;
                    `SF_RLA_OFF:    read_ahead_o  <= 1'b0;
                    default: ;
                endcase
            end
            if (feat_go && sub == `SF_REVERT_ON) begin
                revert_defaults_o <= 1'b1;
            end else if (feat_go && sub == `SF_REVERT_OFF) begin
                revert_defaults_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            puis_enable_o <= 1'b0;
            puis_spinup_o <= 1'b0;
        end else begin
            puis_spinup_o <= feat_go && sub == `SF_PUIS_SPINUP;
            if (feat_go && sub == `SF_PUIS_ON) begin
                puis_enable_o <= 1'b1;
            end else if (feat_go && sub == `SF_PUIS_OFF) begin
                puis_enable_o <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Transfer mode and serial sub-features
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_type_o           <= `XT_PIO_DEFAULT;
            xfer_mode_o           <= 3'h0;
            pio_ready_handshake_o <= 1'b1;
        end else if (feat_go && sub == `SF_XFER_MODE) begin
            xfer_type_o <= cnt[7:3];
            xfer_mode_o <= cnt[2:0];
            pio_ready_handshake_o <= !(cnt == 8'h01);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `LINK_SUBFEATS; gi++) begin : g_link
            always_ff @(posedge clk_i) begin
                if (rst_i || soft_revert) begin
                    link_feat_o[gi] <= 1'b0;
                end else if (feat_go && cnt == 8'(gi)) begin
                    if (sub == `SF_LINK_ON) begin
                        link_feat_o[gi] <= 1'b1;
                    end else if (sub == `SF_LINK_OFF) begin
                        link_feat_o[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Power management level and idle times
    logic [15:0] lpi_calc;
    logic [15:0] stby_calc;
    assign lpi_calc = 16'((16'(cnt) - 16'(`PM_LPI_BASE)) * `LPI_STEP_S)
                      + `LPI_MIN_S;
    assign stby_calc = 16'((16'(cnt) - 16'(`PM_STBY_BASE)) * `STBY_STEP_S)
                       + `STBY_MIN_S;

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_revert) begin
            pm_enable_o              <= 1'b0;
            power_management_level_o <= 8'h00;
            pm_depth_o               <= feat_pkg::PM_NORMAL_IDLE;
            lpi_time_s_o             <= 16'h0000;
            stby_time_s_o            <= 16'h0000;
            lpi_time_set_o           <= 1'b0;
        end else if (feat_go && sub == `SF_PM_OFF) begin
            pm_enable_o    <= 1'b0;
            pm_depth_o     <= feat_pkg::PM_NORMAL_IDLE;
            lpi_time_set_o <= 1'b0;
            stby_time_s_o  <= 16'h0000;
        end else if (feat_go && sub == `SF_PM_ON) begin
            pm_enable_o              <= 1'b1;
            power_management_level_o <= cnt;
            if (cnt >= `PM_NORMAL_BASE) begin
                pm_depth_o     <= feat_pkg::PM_NORMAL_IDLE;
                lpi_time_set_o <= 1'b0;
                stby_time_s_o  <= 16'h0000;
            end else if (cnt >= `PM_LPI_BASE) begin
                pm_depth_o     <= feat_pkg::PM_LOW_POWER_IDLE;
                lpi_time_s_o   <= lpi_calc;
                lpi_time_set_o <= 1'b1;
                stby_time_s_o  <= 16'h0000;
            end else begin
                pm_depth_o <= feat_pkg::PM_LOW_SPEED_STANDBY;
                if (cnt >= `PM_STBY_BASE) begin
                    stby_time_s_o <= stby_calc;
                end else begin
                    stby_time_s_o <= `STBY_MIN_S;
                end
                if (!lpi_time_set_o) begin
                    lpi_time_s_o   <= `LPI_MIN_S;
                    lpi_time_set_o <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Host interface sector time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pio_sector_time_o <= 16'h0000;
            dma_sector_time_o <= 16'h0000;
            full_rate_pio_o   <= 1'b1;
            full_rate_dma_o   <= 1'b1;
        end else if (feat_go && sub == `SF_SECTOR_TIME) begin
            pio_sector_time_o <= {cmd_lba_low_i, cnt};
            dma_sector_time_o <= {cmd_lba_high_i, cmd_lba_mid_i};
            full_rate_pio_o   <= ({cmd_lba_low_i, cnt} == 16'h0000);
            full_rate_dma_o   <= ({cmd_lba_high_i, cmd_lba_mid_i}
                                  == 16'h0000);
        end
    end

    // ==========================================================
    // Checks
    temp_bad_a: assert property (@(posedge clk_i) disable iff (rst_i)
        is_temp && cmd_feature_i != 8'h01 && !status_flags_o[7]
        |-> ##2 error_flags_o[2] && status_flags_o[0])
        else $error("bad sense feature not aborted");
    undef_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
        is_feat && !sub_known(cmd_feature_i) && !status_flags_o[7]
        |-> ##2 error_flags_o[2])
        else $error("undefined subcode not aborted");
    cache_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        spares_exhausted_i |=> !write_cache_o)
        else $error("cache not forced off");
    busy_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |-> !status_flags_o[7] && $past(status_flags_o[7]))
        else $error("busy not cleared at completion");
    err_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |-> status_flags_o[0] == error_flags_o[2])
        else $error("error and abort disagree");
    lpi_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pm_depth_o == feat_pkg::PM_LOW_POWER_IDLE
        |-> lpi_time_s_o >= 16'd120 && lpi_time_s_o <= 16'd435
            && stby_time_s_o == 16'h0000)
        else $error("idle time out of range");
    stby_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
        feat_go && sub == 8'h05 && cnt != 8'h00 && cnt < 8'h40
        |=> stby_time_s_o == 16'd600 && lpi_time_set_o)
        else $error("standby time not 600 s");
    pm_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        feat_go && sub == 8'h85 |=> pm_depth_o == feat_pkg::PM_NORMAL_IDLE)
        else $error("disable did not restore normal idle");
    zero_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        full_rate_dma_o == (dma_sector_time_o == 16'h0000))
        else $error("full rate flag mismatch");
    temp_cov: cover property (@(posedge clk_i) is_temp ##2 done_o);
    apm_cov: cover property (@(posedge clk_i)
        pm_depth_o == feat_pkg::PM_LOW_SPEED_STANDBY);
    abort_cov: cover property (@(posedge clk_i) done_o && error_flags_o[2]);
endmodule // feature_cmds

// *** hw/feat_defs.svh ***
// Constants for the feature and temperature-sense command decoder
`ifndef FEAT_DEFS_SVH
`define FEAT_DEFS_SVH
`define OP_TEMP_SENSE     8'hf0
`define OP_SET_FEATURE    8'hef
`define TEMP_FEATURE      8'h01
`define SF_WCACHE_ON      8'h02
`define SF_XFER_MODE      8'h03
`define SF_PM_ON          8'h05
`define SF_PUIS_ON        8'h06
`define SF_PUIS_SPINUP    8'h07
`define SF_LINK_ON        8'h10
`define SF_SECTOR_TIME    8'h43
`define SF_RLA_OFF        8'h55
`define SF_REVERT_OFF     8'h66
`define SF_WCACHE_OFF     8'h82
`define SF_PM_OFF         8'h85
`define SF_PUIS_OFF       8'h86
`define SF_LINK_OFF       8'h90
`define SF_RLA_ON         8'haa
`define SF_REVERT_ON      8'hcc
`define XT_PIO_DEFAULT    5'h00
`define XT_PIO_FLOW       5'h01
`define XT_MW_DMA         5'h04
`define XT_ULTRA_DMA      5'h08
`define XM_PIO_MAX        3'h4
`define XM_MW_MAX         3'h2
`define XM_UDMA_MAX       3'h6
`define PM_LPI_BASE       8'h80
`define PM_NORMAL_BASE    8'hc0
`define PM_STBY_BASE      8'h40
`define LPI_STEP_S        16'h0005
`define LPI_MIN_S         16'h0078
`define STBY_STEP_S       16'h003c
`define STBY_MIN_S        16'h0258
`define TEMP_OFFSET_C     8'h14
`define TEMP_MAX_C        8'h6b
`define ERR_ABORT_BIT     2
`define ST_BUSY_BIT       7
`define ST_READY_BIT      6
`define ST_ERROR_BIT      0
`define LINK_SUBFEATS     7
`endif

// *** hw/feat_pkg.sv ***
// Types for the feature and temperature-sense command decoder
package feat_pkg;
    typedef enum logic [1:0] {
        PM_NORMAL_IDLE,
        PM_LOW_POWER_IDLE,
        PM_LOW_SPEED_STANDBY
    } pm_depth_t;
endpackage

// *** hw/temp_encode.sv ***
// Temperature to result-code encoder with saturation
`timescale 1ns/1ps
`include "feat_defs.svh"
module temp_encode (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Signed temperature in whole degrees C
    input  wire logic signed [7:0] temp_c_i,
    // Encoded value
    output logic             [7:0] code_o
);
    logic signed [9:0] half_deg;
    always_comb begin
        half_deg = 10'((10'(temp_c_i) + 10'(`TEMP_OFFSET_C)) * 2);
    end
    // Saturate at both ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_o <= 8'h00;
        end else if (temp_c_i <= -$signed(9'(`TEMP_OFFSET_C))) begin
            code_o <= 8'h00;
        end else if (temp_c_i > $signed(9'(`TEMP_MAX_C))) begin
            code_o <= 8'hff;
        end else begin
            code_o <= half_deg[7:0];
        end
    end
endmodule // temp_encode

// *** verif/host_model.sv ***
// Host adapter model that writes task-file commands
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic       clk_i,
    // Completion from the device
    input  wire logic       done_i,
    // Task-file command
    output logic            cmd_valid_o,
    output logic [7:0]      opcode_o,
    output logic [7:0]      feature_o,
    output logic [7:0]      count_o,
    output logic [7:0]      lba_low_o,
    output logic [7:0]      lba_mid_o,
    output logic [7:0]      lba_high_o
);
    // ==========================================
    // Idle lines
    initial begin
        cmd_valid_o = 1'b0;
        {opcode_o, feature_o, count_o} = 24'h000000;
        {lba_high_o, lba_mid_o, lba_low_o} = 24'h000000;
    end

    // ==========================================
    // Command write, then bounded wait for done
    task automatic send(input logic [7:0] op, ft, cnt, lo, mi, hi,
                        output logic ok);
        int n;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        opcode_o    = op;
        feature_o   = ft;
        count_o     = cnt;
        {lba_high_o, lba_mid_o, lba_low_o} = {hi, mi, lo};
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // Released lines show the inverse of the last value
        {opcode_o, feature_o, count_o} = ~{op, ft, cnt};
        {lba_high_o, lba_mid_o, lba_low_o} = ~{hi, mi, lo};
        ok = 1'b0;
        for (n = 0; n < 8 && !ok; n++) begin
            @(posedge clk_i);
            #1;
            ok = (done_i === 1'b1);
        end
    endtask
endmodule // host_model

// *** verif/tb.sv ***
// Self-checking bench for the feature and temperature-sense decoder
`timescale 1ns/1ps
`include "feat_defs.svh"
module tb;
    // ==========================================
    // Signals
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        soft_reset_i = 1'b0;
    logic        cmd_valid_i, spares_exhausted_i;
    logic [7:0]  cmd_opcode_i, cmd_feature_i, cmd_count_i;
    logic [7:0]  cmd_lba_low_i, cmd_lba_mid_i, cmd_lba_high_i;
    logic signed [7:0] temp_c_i;
    logic [7:0]  result_count_o, error_flags_o, status_flags_o;
    logic        done_o, write_cache_o, read_ahead_o, revert_defaults_o;
    logic        release_irq_o, puis_enable_o, puis_spinup_o;
    logic        pio_ready_handshake_o, pm_enable_o, lpi_time_set_o;
    logic [4:0]  xfer_type_o;
    logic [2:0]  xfer_mode_o;
    logic [`LINK_SUBFEATS-1:0] link_feat_o;
    logic [7:0]  power_management_level_o;
    feat_pkg::pm_depth_t pm_depth_o;
    logic [15:0] lpi_time_s_o, stby_time_s_o;
    logic [15:0] pio_sector_time_o, dma_sector_time_o;
    logic        full_rate_pio_o, full_rate_dma_o;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cycles = 0;
    logic        spin_seen = 1'b0;
    wire logic [3:0] flags = {revert_defaults_o, puis_enable_o,
                              read_ahead_o, write_cache_o};

    always #2 clk_i = ~clk_i;

    // Remember the one-cycle spin-up pulse
    always @(posedge clk_i) begin
        if (puis_spinup_o) begin
            spin_seen <= 1'b1;
        end
    end

    feature_cmds u_dut (
        .clk_i, .rst_i, .soft_reset_i, .cmd_valid_i, .cmd_opcode_i,
        .cmd_feature_i, .cmd_count_i, .cmd_lba_low_i, .cmd_lba_mid_i,
        .cmd_lba_high_i, .temp_c_i, .spares_exhausted_i, .result_count_o,
        .error_flags_o, .status_flags_o, .done_o, .write_cache_o,
        .read_ahead_o, .revert_defaults_o, .release_irq_o, .puis_enable_o,
        .puis_spinup_o, .pio_ready_handshake_o, .xfer_type_o, .xfer_mode_o,
        .link_feat_o, .pm_enable_o, .power_management_level_o, .pm_depth_o,
        .lpi_time_s_o, .stby_time_s_o, .lpi_time_set_o, .pio_sector_time_o,
        .dma_sector_time_o, .full_rate_pio_o, .full_rate_dma_o
    );

    host_model u_host (
        .clk_i, .done_i(done_o), .cmd_valid_o(cmd_valid_i),
        .opcode_o(cmd_opcode_i), .feature_o(cmd_feature_i),
        .count_o(cmd_count_i), .lba_low_o(cmd_lba_low_i),
        .lba_mid_o(cmd_lba_mid_i), .lba_high_o(cmd_lba_high_i)
    );

    // ==========================================
    // Helpers
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [7:0] op, ft, cnt, lo = 8'h00,
                       mi = 8'h00, hi = 8'h00, input logic command_abort_bit = 1'b0);
        logic ok;
        u_host.send(op, ft, cnt, lo, mi, hi, ok);
        check("done", ok, 1'b1);
        check("error", error_flags_o, command_abort_bit ? 8'h04 : 8'h00);
        check("status", status_flags_o, command_abort_bit ? 8'h41 : 8'h40);
    endtask

    task automatic hard_reset();
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        check("cache", write_cache_o, 1'b1);
        check("ahead", read_ahead_o, 1'b1);
        check("revert", revert_defaults_o, 1'b0);
        check("release", release_irq_o, 1'b0);
        check("depth", pm_depth_o, feat_pkg::PM_NORMAL_IDLE);
    endtask

    task automatic soft_reset();
        soft_reset_i = 1'b1;
        @(posedge clk_i);
        #1;
        soft_reset_i = 1'b0;
        @(posedge clk_i);
        #1;
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    // ==========================================
    // Tests
    initial begin
        logic [7:0] subs [8] = '{8'h82, 8'h02, 8'h55, 8'haa,
                                 8'h06, 8'h86, 8'hcc, 8'h66};
        logic [7:0] vals = 8'b01011010;
        logic [23:0] abts [10] = '{24'hef0000, 24'hefff00, 24'hf00200,
            24'hef0500, 24'hef05ff, 24'hef030d, 24'hef0323, 24'hef0347,
            24'hef0310, 24'hef1005};
        logic [7:0] xm [5] = '{8'h0c, 8'h22, 8'h46, 8'h01, 8'h00};
        logic signed [7:0] temps [8] = '{-8'sd128, -8'sd21, -8'sd20,
            -8'sd19, 8'sd0, 8'sd107, 8'sd108, 8'sd127};
        logic [7:0] tcode [8] = '{8'h00, 8'h00, 8'h00, 8'h02,
                                  8'h28, 8'hfe, 8'hff, 8'hff};
        logic [2:0] lk [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
        logic ok;
        temp_c_i = 8'sd0;
        spares_exhausted_i = 1'b0;
        hard_reset();
        for (int i = 0; i < 8; i++) begin
            cmd(8'hef, subs[i], 8'h00);
            check("toggle", flags[i/2], vals[i]);
        end
        check("spinup", spin_seen, 1'b0);
        cmd(8'hef, 8'h07, 8'h00);
        check("spinup", spin_seen, 1'b1);
        for (int i = 0; i < 10; i++)
            cmd(abts[i][23:16], abts[i][15:8], abts[i][7:0], 8'h00, 8'h00,
                8'h00, 1'b1);
        for (int i = 0; i < 5; i++) begin
            cmd(8'hef, 8'h03, xm[i]);
            check("type", xfer_type_o, xm[i][7:3]);
            check("mode", xfer_mode_o, xm[i][2:0]);
            check("ready", pio_ready_handshake_o, xm[i] != 8'h01);
        end
        cmd(8'hef, 8'h06, 8'h00);
        for (int i = 0; i < 8; i++) begin
            temp_c_i = temps[i];
            cmd(8'hf0, 8'h01, 8'h00);
            check("temp", result_count_o, tcode[i]);
        end
        cmd(8'hef, 8'h86, 8'h00);
        u_host.send(8'h70, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, ok);
        check("ignored", ok, 1'b0);
        spares_exhausted_i = 1'b1;
        cmd(8'hef, 8'h02, 8'h00);
        check("cache", write_cache_o, 1'b0);
        spares_exhausted_i = 1'b0;
        for (int i = 0; i < 5; i++) begin
            cmd(8'hef, 8'h10, {5'h00, lk[i]});
            check("link", link_feat_o[lk[i]], 1'b1);
            cmd(8'hef, 8'h90, {5'h00, lk[i]});
            check("link", link_feat_o[lk[i]], 1'b0);
        end
        cmd(8'hef, 8'h05, 8'h80);
        check("pm on", pm_enable_o, 1'b1);
        check("depth", pm_depth_o, feat_pkg::PM_LOW_POWER_IDLE);
        check("lpi", lpi_time_s_o, 16'h0078);
        cmd(8'hef, 8'h05, 8'hbf);
        check("lpi", lpi_time_s_o, 16'h01b3);
        cmd(8'hef, 8'h05, 8'h7f);
        check("depth", pm_depth_o, feat_pkg::PM_LOW_SPEED_STANDBY);
        check("stby", stby_time_s_o, 16'h111c);
        check("lpi", lpi_time_s_o, 16'h01b3);
        cmd(8'hef, 8'h05, 8'h40);
        check("stby", stby_time_s_o, 16'h0258);
        soft_reset();
        check("depth", pm_depth_o, feat_pkg::PM_LOW_SPEED_STANDBY);
        cmd(8'hef, 8'h85, 8'h00);
        check("depth", pm_depth_o, feat_pkg::PM_NORMAL_IDLE);
        check("pm off", pm_enable_o, 1'b0);
        check("lpi set", lpi_time_set_o, 1'b0);
        cmd(8'hef, 8'h05, 8'hc0);
        check("depth", pm_depth_o, feat_pkg::PM_NORMAL_IDLE);
        cmd(8'hef, 8'h05, 8'h3f);
        check("level", power_management_level_o, 8'h3f);
        check("stby", stby_time_s_o, 16'h0258);
        check("lpi", lpi_time_s_o, 16'h0078);
        cmd(8'hef, 8'hcc, 8'h00);
        cmd(8'hef, 8'h82, 8'h00);
        soft_reset();
        check("depth", pm_depth_o, feat_pkg::PM_NORMAL_IDLE);
        check("cache", write_cache_o, 1'b1);
        cmd(8'hef, 8'h43, 8'h34, 8'h12, 8'h78, 8'h56);
        check("pio", pio_sector_time_o, 16'h1234);
        check("dma", dma_sector_time_o, 16'h5678);
        check("full", {full_rate_pio_o, full_rate_dma_o}, 2'b00);
        cmd(8'hef, 8'h43, 8'h00);
        check("full", {full_rate_pio_o, full_rate_dma_o}, 2'b11);
        cmd(8'hef, 8'h05, 8'h90);
        hard_reset();
        final_report();
    end
endmodule // tb
